// [src/amp_pkg.sv]
// constants and types shared by the external memory strobe port
package amp_pkg;
    localparam int unsigned loc_width = 24;
    localparam int unsigned data_width = 16;
    localparam int unsigned bank_count = 4;
    // bank decode: top two address bits pick the bank
    localparam int unsigned bank_lsb = 22;
    localparam int unsigned bank_width = 2;
    localparam logic [3:0] select_idle = 4'hf;
    localparam logic [1:0] bank_two = 2'h2;
    localparam logic [1:0] bank_three = 2'h3;
    localparam logic [loc_width-1:0] loc_reset = 24'h000000;
    localparam logic [data_width-1:0] data_reset = 16'h0000;
    // turnaround cycles with both strobes released between accesses
    localparam logic [1:0] gap_cycles = 2'h1;
    // strobe cycles ignored while the synchroniser still shows the pre-select acknowledge
    localparam logic [1:0] settle_cycles = 2'h1;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_setup = 2'b01,
        st_strobe = 2'b10,
        st_gap = 2'b11
    } port_state_t;
endpackage

// [src/sync2.sv]
// two-flop synchroniser for a level from a pin
module sync2 (
    input wire logic clock_i, // core clock
    input wire logic rst_n_i, // synchronous reset, active low
    input wire logic level_i, // asynchronous level
    output logic level_o // synchronised level
);
    typedef struct packed {
        logic first;
        logic second;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    always_comb begin
        next_st.first = level_i;
        next_st.second = st.first;
        if (!rst_n_i) begin
            // idle level of a pulled-up pin
            next_st = '1;
        end
    end

    always_ff @(posedge clock_i) begin
        st <= next_st;
    end

    assign level_o = st.second;
endmodule

// [src/async_memory_strobe_port.sv]
// asynchronous external memory port: bank selects, strobes, wait states
// Overview of operation
// - while the acknowledge input is low the access is held and not completed.
// - one active-low select per bank and only the addressed bank is asserted.
// - selects are decoded from the address and change in the cycle the address changes.
// - all selects are inactive whenever no external access is in progress.
// - a conditional access asserts a select and runs only when its condition is true.
// - the read strobe is asserted for every word read.
// - the write strobe is asserted for every word written.
// - on the large package, banks 2 and 3 are alternate flag pin functions; flags are inputs after reset.
// - after reset the address outputs are in memory port mode, not flag or pwm.
module async_memory_strobe_port (
    input wire logic clock_i, // core clock, 200 MHz
    input wire logic rst_n_i, // synchronous reset, active low
    input wire logic req_valid_i, // core requests one word access
    input wire logic req_write_i, // 1 write, 0 read
    input wire logic req_cond_i, // instruction condition result
    input wire logic [amp_pkg::loc_width-1:0] req_loc_i, // word address
    input wire logic [amp_pkg::data_width-1:0] req_wdata_i, // write data
    output logic req_ready_o, // port idle, request taken
    output logic done_o, // one-cycle pulse, access complete
    output logic [amp_pkg::data_width-1:0] rdata_o, // captured read data
    input wire logic large_package_i, // strap: large package fitted
    input wire logic flag_two_select_i, // flag pin two used as bank 2 select
    input wire logic flag_three_select_i, // flag pin three used as bank 3 select
    input wire logic ext_access_ack_i, // pin, low inserts wait states
    output logic [1:0] bank_select_n_o, // banks 0 and 1 selects, active low
    output logic general_flag_pin_two_o, // flag pin two output value
    output logic general_flag_pin_two_oe_o, // low while driven
    output logic general_flag_pin_three_o, // flag pin three output value
    output logic general_flag_pin_three_oe_o, // low while driven
    output logic read_strobe_o, // active-low read strobe
    output logic write_strobe_o, // active-low write strobe
    output logic ext_memory_port_mode_o, // address pins in memory port mode
    output logic [amp_pkg::loc_width-1:0] ext_location_bus_o, // address pins
    output logic [amp_pkg::data_width-1:0] ext_data_o, // data pins out
    output logic ext_data_oe_o, // low while data driven
    input wire logic [amp_pkg::data_width-1:0] ext_data_i // data pins in
);
    import amp_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        port_state_t fsm;
        logic write;
        logic [1:0] gap;
        logic ready;
        logic done;
        logic [data_width-1:0] rdata;
        logic [bank_count-1:0] sel_n;
        logic rd_n;
        logic wr_n;
        logic port_mode;
        logic [loc_width-1:0] loc;
        logic [data_width-1:0] wdata;
        logic data_oe_n;
        logic two_oe_n;
        logic three_oe_n;
    } port_st_t;

    port_st_t st;
    port_st_t next_st;
    logic ack_sync;
    logic [bank_width-1:0] bank;
    logic start;
    logic settled;
    logic complete;
    logic [bank_count-1:0] decode_n;
    logic two_drive;
    logic three_drive;

    // acknowledge is a pin, so two flops before any logic
    sync2 ack_sync_u (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .level_i(ext_access_ack_i),
        .level_o(ack_sync)
    );

    assign bank = req_loc_i[bank_lsb +: bank_width];

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    // false condition stays idle
    assign start = req_valid_i && st.ready && req_cond_i;

    always_comb begin
        decode_n = select_idle;
        decode_n[bank] = 1'b0;
    end

    // ------------------------------------------------------------
    // wait states
    // ------------------------------------------------------------
    // the synchroniser still shows the pre-select level in the first strobe cycle
    assign settled = st.gap == 2'h0;
    // limitation: a device must pull acknowledge low within one cycle of its select
    // settled acknowledge only
    assign complete = settled && ack_sync;

    // ------------------------------------------------------------
    // flag pins
    // ------------------------------------------------------------
    // large package only
    assign two_drive = large_package_i && flag_two_select_i;
    assign three_drive = large_package_i && flag_three_select_i;

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.port_mode = 1'b1;
        // flag pins driven only as selects
        next_st.two_oe_n = !two_drive;
        next_st.three_oe_n = !three_drive;
        unique case (st.fsm)
            st_idle: begin
                if (start) begin
                    next_st.fsm = st_setup;
                    next_st.ready = 1'b0;
                    next_st.write = req_write_i;
                    next_st.loc = req_loc_i;
                    next_st.sel_n = decode_n;
                    next_st.wdata = req_wdata_i;
                    next_st.data_oe_n = !req_write_i;
                end
            end
            st_setup: begin
                next_st.fsm = st_strobe;
                // first strobe cycle is not settled
                next_st.gap = settle_cycles;
                next_st.rd_n = st.write;
                next_st.wr_n = !st.write;
            end
            st_strobe: begin
                if (!settled) begin
                    next_st.gap = st.gap - 2'h1;
                end
                if (complete) begin
                    next_st.fsm = st_gap;
                    next_st.rd_n = 1'b1;
                    next_st.wr_n = 1'b1;
                    next_st.sel_n = select_idle;
                    next_st.data_oe_n = 1'b1;
                    next_st.done = 1'b1;
                    // data pins taken unsynchronised; the device holds them while acknowledging
                    if (!st.write) begin
                        next_st.rdata = ext_data_i;
                    end
                    next_st.gap = gap_cycles;
                end
            end
            st_gap: begin
                // turnaround: both strobes stay released before the next select
                if (st.gap == 2'h1) begin
                    next_st.fsm = st_idle;
                    next_st.ready = 1'b1;
                end
                next_st.gap = st.gap - 2'h1;
            end
        endcase
        if (!rst_n_i) begin
            next_st.fsm = st_idle;
            next_st.write = 1'b0;
            next_st.gap = 2'h0;
            next_st.ready = 1'b1;
            next_st.done = 1'b0;
            next_st.rdata = data_reset;
            next_st.sel_n = select_idle;
            next_st.rd_n = 1'b1;
            next_st.wr_n = 1'b1;
            next_st.port_mode = 1'b1;
            next_st.loc = loc_reset;
            next_st.wdata = data_reset;
            next_st.data_oe_n = 1'b1;
            next_st.two_oe_n = 1'b1;
            next_st.three_oe_n = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        st <= next_st;
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign req_ready_o = st.ready;
    assign done_o = st.done;
    assign rdata_o = st.rdata;
    assign bank_select_n_o = st.sel_n[1:0];
    // flag pins carry the bank 2 and 3 select bits
    assign general_flag_pin_two_o = st.sel_n[bank_two];
    assign general_flag_pin_two_oe_o = st.two_oe_n;
    assign general_flag_pin_three_o = st.sel_n[bank_three];
    assign general_flag_pin_three_oe_o = st.three_oe_n;
    assign read_strobe_o = st.rd_n;
    assign write_strobe_o = st.wr_n;
    assign ext_memory_port_mode_o = st.port_mode;
    assign ext_location_bus_o = st.loc;
    assign ext_data_o = st.wdata;
    assign ext_data_oe_o = st.data_oe_n;
endmodule

// [tb/amp_monitor.sv]
// assertion checker for the external memory strobe port
module amp_monitor (
    input wire logic clock_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic req_valid_i, // request
    input wire logic req_write_i, // direction
    input wire logic req_cond_i, // condition
    input wire logic [amp_pkg::loc_width-1:0] req_loc_i, // address
    input wire logic req_ready_o, // idle
    input wire logic done_o, // complete
    input wire logic ext_access_ack_i, // ack pin
    input wire logic [1:0] bank_select_n_o, // selects
    input wire logic read_strobe_o, // read
    input wire logic write_strobe_o, // write
    input wire logic ext_memory_port_mode_o, // mode
    input wire logic [amp_pkg::loc_width-1:0] ext_location_bus_o // pins
);
    timeunit 1ns;
    timeprecision 100ps;
    import amp_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire take = req_valid_i && req_ready_o && req_cond_i;
    property p_excl; !(!read_strobe_o && !write_strobe_o); endproperty
    a_excl: assert property (p_excl) else $error("both strobes low");
    property p_idle; req_ready_o |-> bank_select_n_o == 2'h3; endproperty
    a_idle: assert property (p_idle) else $error("select while idle");
    property p_addr; take |=> ext_location_bus_o == $past(req_loc_i); endproperty
    a_addr: assert property (p_addr) else $error("address late");
    property p_dec; take && !req_loc_i[23] |=>
        bank_select_n_o == {!$past(req_loc_i[22]), $past(req_loc_i[22])}; endproperty
    a_dec: assert property (p_dec) else $error("bad select decode");
    property p_cond; req_valid_i && req_ready_o && !req_cond_i |=> req_ready_o; endproperty
    a_cond: assert property (p_cond) else $error("false condition ran");
    property p_rd; take && !req_write_i |-> ##2 !read_strobe_o && write_strobe_o; endproperty
    a_rd: assert property (p_rd) else $error("no read strobe");
    property p_wr; take && req_write_i |-> ##2 !write_strobe_o && read_strobe_o; endproperty
    a_wr: assert property (p_wr) else $error("no write strobe");
    property p_wait; done_o |-> $past(ext_access_ack_i, 3); endproperty
    a_wait: assert property (p_wait) else $error("done without acknowledge");
    property p_mode; ext_memory_port_mode_o; endproperty
    a_mode: assert property (p_mode) else $error("not in port mode");
    c_read: cover property (take && !req_write_i);
    c_write: cover property (take && req_write_i);
    c_wait: cover property (!ext_access_ack_i && !read_strobe_o);
endmodule
bind async_memory_strobe_port amp_monitor mon (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_cond_i(req_cond_i),
    .req_loc_i(req_loc_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .ext_access_ack_i(ext_access_ack_i), .bank_select_n_o(bank_select_n_o),
    .read_strobe_o(read_strobe_o), .write_strobe_o(write_strobe_o),
    .ext_memory_port_mode_o(ext_memory_port_mode_o), .ext_location_bus_o(ext_location_bus_o));

// [tb/ext_mem_model.sv]
// behavioural memory behind the port, with programmable wait states
module ext_mem_model (
    input wire logic clock_i, // clock
    input wire logic busy_i, // a select active
    input wire logic read_strobe_i, // active low
    input wire logic write_strobe_i, // active low
    input wire logic [amp_pkg::loc_width-1:0] loc_i, // address
    input wire logic [amp_pkg::data_width-1:0] data_i, // data pins
    input wire logic [7:0] wait_i, // wait states
    output logic ext_access_ack_o, // low holds
    output logic [amp_pkg::data_width-1:0] data_o, // read data
    output logic [amp_pkg::data_width-1:0] stored_o // last written
);
    timeunit 1ns;
    timeprecision 100ps;
    import amp_pkg::*;
    logic [7:0] held;
    always_ff @(posedge clock_i) begin
        held <= busy_i ? held + 8'h01 : 8'h00;
        if (!write_strobe_i) stored_o <= data_i;
    end
    assign ext_access_ack_o = !busy_i || held >= wait_i;
    assign data_o = read_strobe_i ? 16'hffff : loc_i[15:0] ^ 16'h5a5a;
endmodule

// [tb/tb.sv]
// self-checking bench for the external memory strobe port
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import amp_pkg::*;
    typedef struct packed {logic wr; logic cond; logic [23:0] loc; logic [15:0] wd;
        logic [7:0] wt;} row_t;
    localparam row_t rows [6] = '{'{1'b0, 1'b1, 24'h000123, 16'h0, 8'h0},
        '{1'b1, 1'b1, 24'h400456, 16'hbeef, 8'h3}, '{1'b0, 1'b1, 24'h800789, 16'h0, 8'h5},
        '{1'b1, 1'b1, 24'hc0abcd, 16'h1234, 8'h0}, '{1'b0, 1'b0, 24'h000010, 16'h0, 8'h0},
        '{1'b0, 1'b1, 24'h400abc, 16'h0, 8'h8}};
    logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, wr = 1'b0, cond = 1'b0, big = 1'b1;
    logic [23:0] loc = loc_reset, bus;
    logic [15:0] wd = data_reset, rdata, dout, din, mdata, stored;
    logic [7:0] wt = 8'h0;
    logic [1:0] fsel = 2'h3;
    logic [3:0] seen;
    logic [1:0] sel;
    logic ready, done, ack, f2, f2e, f3, f3e, rd_n, wr_n, mode, doe;
    int errors = 0, tests_run = 0, lat;
    wire busy = sel != 2'h3 || !(f2 | f2e) || !(f3 | f3e);
    assign din = doe ? mdata : dout;
    async_memory_strobe_port dut (.clock_i(clk), .rst_n_i(rst_n), .req_valid_i(valid),
        .req_write_i(wr), .req_cond_i(cond), .req_loc_i(loc), .req_wdata_i(wd),
        .req_ready_o(ready), .done_o(done), .rdata_o(rdata), .large_package_i(big),
        .flag_two_select_i(fsel[0]), .flag_three_select_i(fsel[1]), .ext_access_ack_i(ack),
        .bank_select_n_o(sel), .general_flag_pin_two_o(f2), .general_flag_pin_two_oe_o(f2e),
        .general_flag_pin_three_o(f3), .general_flag_pin_three_oe_o(f3e),
        .read_strobe_o(rd_n), .write_strobe_o(wr_n), .ext_memory_port_mode_o(mode),
        .ext_location_bus_o(bus), .ext_data_o(dout), .ext_data_oe_o(doe), .ext_data_i(din));
    ext_mem_model mem (.clock_i(clk), .busy_i(busy), .read_strobe_i(rd_n), .write_strobe_i(wr_n),
        .loc_i(bus), .data_i(din), .wait_i(wt), .ext_access_ack_o(ack), .data_o(mdata),
        .stored_o(stored));
    initial forever #2.5 clk = ~clk;
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one request, then count cycles to done while noting which selects went low
    task automatic run(input row_t r);
        @(posedge clk) #1;
        {valid, wr, cond, loc, wd, wt} = {1'b1, r};
        @(posedge clk) #1;
        valid = 1'b0;
        seen = 4'h0;
        for (lat = 1; lat < 40 && done !== 1'b1; lat++) begin
            seen |= ~{f3 | f3e, f2 | f2e, sel};
            @(posedge clk) #1;
        end
        if (r.cond && lat == 40) begin
            errors++;
            test_done();
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1;
        check("reset outputs", 32'hff, 32'({ready, rd_n, wr_n, sel, f2e, f3e, mode}));
        rst_n = 1'b1;
        foreach (rows[i]) begin
            run(rows[i]);
            check("select", 32'(rows[i].cond) << rows[i].loc[23:22], 32'(seen));
            check("latency", 1, 32'(lat >= 4 + rows[i].wt));
            if (!rows[i].cond) check("dropped", 40, lat);
            else if (rows[i].wr) check("written", 32'(rows[i].wd), 32'(stored));
            else check("read", 32'(rows[i].loc[15:0] ^ 16'h5a5a), 32'(rdata));
        end
        // mid-access reset: the held strobe must drop with every select
        @(posedge clk) #1;
        {valid, wr, cond, loc, wd, wt} = {1'b1, rows[5]};
        @(posedge clk) #1;
        valid = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("strobe held", 32'h0, 32'(rd_n));
        rst_n = 1'b0;
        @(posedge clk) #1;
        check("reset mid access", 32'hff, 32'({ready, rd_n, wr_n, sel, f2e, f3e, mode}));
        rst_n = 1'b1;
        run(rows[0]);
        check("read after reset", 32'(rows[0].loc[15:0] ^ 16'h5a5a), 32'(rdata));
        big = 1'b0;
        run(rows[2]);
        check("flag oe", 32'h3, 32'({f2e, f3e}));
        big = 1'b1;
        fsel = 2'h2;
        @(posedge clk) #1;
        check("flag enable", 32'h2, 32'({f2e, f3e}));
        test_done();
    end
endmodule
